// *** hdl/fsp_pkg.sv ***
// Constants and types shared by the flash status and protection block.
package fsp_pkg;
   localparam int FSP_ADDR_W = 20;
   localparam logic [7:0] FSP_OFF_STATUS = 8'h00;
   localparam logic [7:0] FSP_OFF_CMD = 8'h04;
   localparam logic [7:0] FSP_OFF_OP = 8'h08;
   localparam int FSP_BIT_BUSY = 0;
   localparam int FSP_BIT_WEL = 1;
   localparam int FSP_BIT_LVL_LO = 2;
   localparam int FSP_BIT_LVL_HI = 5;
   localparam int FSP_BIT_AAI = 6;
   localparam int FSP_BIT_LOCK = 7;
   localparam logic [3:0] FSP_LVL_RESET = 4'h7;
   localparam logic FSP_LOCK_RESET = 1'b0;
   localparam int FSP_CMD_WREN_BIT = 0;
   localparam int FSP_CMD_WRITE_DISABLE_CMD_BIT = 1;
   localparam int FSP_CMD_PAUSE_BIT = 2;
   localparam int FSP_OP_KIND_LO = 20;
   localparam int FSP_OP_KIND_HI = 22;
   localparam int FSP_OP_BUSY_BIT = 31;
   localparam logic [19:0] FSP_BASE_L1 = 20'hf0000;
   localparam logic [19:0] FSP_BASE_L2 = 20'he0000;
   localparam logic [19:0] FSP_BASE_L3 = 20'hc0000;
   localparam logic [19:0] FSP_BASE_L4 = 20'h80000;
   localparam logic [20:0] FSP_AAI_STEP = 21'h000002;
   localparam int FSP_SYNC_W = 4;
   localparam int FSP_SYNC_SCK = 0;
   localparam int FSP_SYNC_CS = 1;
   localparam int FSP_SYNC_PIN = 2;
   localparam int FSP_SYNC_WP = 3;
   localparam logic [3:0] FSP_SYNC_RESET = 4'hf;
   typedef enum logic [2:0] {
      FSP_OP_BYTE = 3'b000,
      FSP_OP_SECTOR = 3'b001,
      FSP_OP_BLOCK = 3'b010,
      FSP_OP_CHIP = 3'b011,
      FSP_OP_AAI_START = 3'b100,
      FSP_OP_AAI_NEXT = 3'b101
   } fsp_op_t;
   typedef enum logic {
      FSP_PIN_RESET = 1'b0,
      FSP_PIN_PAUSE = 1'b1
   } fsp_pin_t;
   typedef enum logic {
      FSP_LIVE = 1'b0,
      FSP_HELD = 1'b1
   } fsp_hold_t;
endpackage

// *** hdl/fsp_status_protect.sv ***
// Status byte, write protection and pause control of a serial flash, with an APB slave.
// Notes on behaviour
// - Once pause is chosen the shared pin stays a pause input until power-up.
// - Pause needs select low; the serial sequence freezes without losing its bit count.
// - Pause starts when the pin is low while serial clock is low, else waits.
// - Pause ends when the pin is high while serial clock is low, else waits.
// - While paused the output floats, input and clock are ignored, pause holds.
// - Raising select while paused aborts the sequence and returns to standby.
// - Status write refused when write-protect is low and lock is 1.
// - Lock flag is status bit 7, read and write, zero at power-up.
// - Write-protect low with lock set freezes lock and level bits.
// - Bit 0 is a read-only busy flag, zero at power-up.
// - While busy only status reads are served.
// - Bit 1 is the write enable latch; when clear, program and erase are refused.
// - Latch clears on reset, disable, finished program or erase, AUTO_INCREMENT_PROGRAM_FLAG end, status write.
// - Bit 6 is read-only auto-increment mode flag, zero at power-up.
// - Bits 2 to 5 are level bits 0 to 3, power-up value 0111.
// - Level bits 2..0 decode the protected upper range; program and erase blocked there.
// - Level bit 3 is reserved, does not change the range, defaults to 0.
// - Whole-array erase runs only when all level bits are zero.
// - After power-up the shared pin is a reset; a command makes it a pause pin.
module fsp_status_protect #(
   parameter int ADDR_W = fsp_pkg::FSP_ADDR_W
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_pause_rst_n,
   input wire logic i_wp_n,
   input wire logic i_so_drive,
   input wire logic i_op_done,
   output logic o_so_oe,
   output logic o_bit_clk,
   output logic o_seq_freeze,
   output logic o_seq_abort,
   output logic o_dev_reset,
   output logic o_op_start,
   output logic [2:0] o_op_kind,
   output logic [ADDR_W-1:0] o_op_addr,
   output logic [7:0] o_status
);
   logic [fsp_pkg::FSP_SYNC_W-1:0] sync1_reg;
   logic [fsp_pkg::FSP_SYNC_W-1:0] sync2_reg;
   logic sck_prev_reg;
   fsp_pkg::fsp_pin_t pin_mode_reg;
   fsp_pkg::fsp_hold_t hold_reg;
   logic busy_reg;
   logic wel_reg;
   logic aai_reg;
   logic [3:0] lvl_reg;
   logic lock_reg;
   logic reject_reg;
   logic [ADDR_W-1:0] aai_addr_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic sck_s;
   logic cs_s;
   logic pin_s;
   logic wp_s;
   logic pin_reset;
   logic acc;
   logic commit;
   logic wr_fire;
   logic wr_status;
   logic wr_cmd;
   logic wr_op;
   logic err_next;
   logic status_ok;
   logic op_ok;
   logic aai_end;
   logic [2:0] op_kind;
   logic [ADDR_W-1:0] op_addr;
   logic [20:0] aai_next;
   logic [7:0] status_byte;

   function automatic logic prot_hit(input logic [2:0] lvl, input logic [ADDR_W-1:0] a);
      case (lvl)
         3'h0: prot_hit = 1'b0;
         3'h1: prot_hit = (a >= fsp_pkg::FSP_BASE_L1);
         3'h2: prot_hit = (a >= fsp_pkg::FSP_BASE_L2);
         3'h3: prot_hit = (a >= fsp_pkg::FSP_BASE_L3);
         3'h4: prot_hit = (a >= fsp_pkg::FSP_BASE_L4);
         default: prot_hit = 1'b1;
      endcase
   endfunction

   // Pin inputs cross into the system clock through two flip-flops.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         sync1_reg <= fsp_pkg::FSP_SYNC_RESET;
         sync2_reg <= fsp_pkg::FSP_SYNC_RESET;
         sck_prev_reg <= 1'b1;
      end else if (i_clk_en) begin
         sync1_reg <= {i_wp_n, i_pause_rst_n, i_cs_n, i_sck};
         sync2_reg <= sync1_reg;
         sck_prev_reg <= sck_s;
      end
   end

   assign sck_s = sync2_reg[fsp_pkg::FSP_SYNC_SCK];
   assign cs_s = sync2_reg[fsp_pkg::FSP_SYNC_CS];
   assign pin_s = sync2_reg[fsp_pkg::FSP_SYNC_PIN];
   assign wp_s = sync2_reg[fsp_pkg::FSP_SYNC_WP];
   assign pin_reset = (pin_mode_reg == fsp_pkg::FSP_PIN_RESET) && !pin_s;

   assign status_byte = {lock_reg, aai_reg, lvl_reg, wel_reg, busy_reg};

   // APB decode; the answer comes one cycle into the access phase.
   assign acc = i_psel && i_penable;
   assign commit = acc && pready_reg;
   assign wr_fire = commit && i_pwrite && !pslverr_reg;
   assign wr_status = wr_fire && (i_paddr == fsp_pkg::FSP_OFF_STATUS);
   assign wr_cmd = wr_fire && (i_paddr == fsp_pkg::FSP_OFF_CMD);
   assign wr_op = wr_fire && (i_paddr == fsp_pkg::FSP_OFF_OP);
   assign op_kind = i_pwdata[fsp_pkg::FSP_OP_KIND_HI:fsp_pkg::FSP_OP_KIND_LO];
   assign op_addr = (op_kind == fsp_pkg::FSP_OP_AAI_NEXT) ? aai_addr_reg : i_pwdata[ADDR_W-1:0];

   always_comb begin
      if (i_paddr == fsp_pkg::FSP_OFF_STATUS) begin
         err_next = i_pwrite && busy_reg;
      end else if (i_paddr == fsp_pkg::FSP_OFF_CMD) begin
         err_next = busy_reg;
      end else if (i_paddr == fsp_pkg::FSP_OFF_OP) begin
         err_next = busy_reg || (i_pwrite && (op_kind > fsp_pkg::FSP_OP_AAI_NEXT));
      end else begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else if (i_clk_en) begin
         pready_reg <= acc && !pready_reg;
         if (acc && !pready_reg) begin
            pslverr_reg <= err_next;
            prdata_reg <= 32'h00000000;
            if (!err_next && !i_pwrite) begin
               if (i_paddr == fsp_pkg::FSP_OFF_STATUS) begin
                  prdata_reg <= {24'h000000, status_byte};
               end else if (i_paddr == fsp_pkg::FSP_OFF_CMD) begin
                  prdata_reg <= {29'h00000000, reject_reg, hold_reg, pin_mode_reg};
               end else begin
                  prdata_reg <= {busy_reg, 8'h00, o_op_kind, o_op_addr};
               end
            end
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // Status writes obey the write-protect pin and the lock flag.
   assign status_ok = wp_s || !lock_reg;

   // Program and erase acceptance.
   always_comb begin
      op_ok = wel_reg;
      case (op_kind)
         fsp_pkg::FSP_OP_CHIP: op_ok = op_ok && (lvl_reg == 4'h0);
         fsp_pkg::FSP_OP_AAI_START: op_ok = op_ok && !aai_reg && !prot_hit(lvl_reg[2:0], op_addr);
         fsp_pkg::FSP_OP_AAI_NEXT: op_ok = op_ok && aai_reg && !prot_hit(lvl_reg[2:0], op_addr);
         default: op_ok = op_ok && !prot_hit(lvl_reg[2:0], op_addr);
      endcase
   end

   // Auto-increment stops at the top of the array or at the first protected word.
   assign aai_next = {1'b0, aai_addr_reg} + fsp_pkg::FSP_AAI_STEP;
   assign aai_end = aai_next[ADDR_W] || prot_hit(lvl_reg[2:0], aai_next[ADDR_W-1:0]);

   // Pin function selection survives everything but power-up.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pin_mode_reg <= fsp_pkg::FSP_PIN_RESET;
      end else if (i_clk_en) begin
         if (wr_cmd && i_pwdata[fsp_pkg::FSP_CMD_PAUSE_BIT]) begin
            pin_mode_reg <= fsp_pkg::FSP_PIN_PAUSE;
         end
      end
   end

   // Pause state follows the pin only while the serial clock is low.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         hold_reg <= fsp_pkg::FSP_LIVE;
         o_seq_abort <= 1'b0;
      end else if (i_clk_en) begin
         o_seq_abort <= 1'b0;
         case (hold_reg)
            fsp_pkg::FSP_LIVE: begin
               if (pin_mode_reg == fsp_pkg::FSP_PIN_PAUSE && !cs_s && !sck_s && !pin_s) begin
                  hold_reg <= fsp_pkg::FSP_HELD;
               end
            end
            fsp_pkg::FSP_HELD: begin
               if (cs_s) begin
                  hold_reg <= fsp_pkg::FSP_LIVE;
                  o_seq_abort <= 1'b1;
               end else if (!sck_s && pin_s) begin
                  hold_reg <= fsp_pkg::FSP_LIVE;
               end
            end
            default: hold_reg <= fsp_pkg::FSP_LIVE;
         endcase
      end
   end

   assign o_seq_freeze = hold_reg;

   // Serial output enable and bit clock are masked while paused.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_so_oe <= 1'b0;
         o_bit_clk <= 1'b0;
         o_dev_reset <= 1'b0;
      end else if (i_clk_en) begin
         o_so_oe <= i_so_drive && !cs_s && !pin_reset && (hold_reg == fsp_pkg::FSP_LIVE);
         o_bit_clk <= sck_s && !sck_prev_reg && !cs_s && (hold_reg == fsp_pkg::FSP_LIVE);
         o_dev_reset <= pin_reset;
      end
   end

   // Protection fields of the status byte.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         lvl_reg <= fsp_pkg::FSP_LVL_RESET;
         lock_reg <= fsp_pkg::FSP_LOCK_RESET;
      end else if (i_clk_en) begin
         if (pin_reset) begin
            lvl_reg <= fsp_pkg::FSP_LVL_RESET;
            lock_reg <= fsp_pkg::FSP_LOCK_RESET;
         end else if (wr_status && status_ok) begin
            lvl_reg <= i_pwdata[fsp_pkg::FSP_BIT_LVL_HI:fsp_pkg::FSP_BIT_LVL_LO];
            lock_reg <= i_pwdata[fsp_pkg::FSP_BIT_LOCK];
         end
      end
   end

   // Write enable latch.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wel_reg <= 1'b0;
      end else if (i_clk_en) begin
         if (pin_reset || wr_status) begin
            wel_reg <= 1'b0;
         end else if (wr_cmd && i_pwdata[fsp_pkg::FSP_CMD_WRITE_DISABLE_CMD_BIT]) begin
            wel_reg <= 1'b0;
         end else if (busy_reg && i_op_done && (!aai_reg || aai_end)) begin
            wel_reg <= 1'b0;
         end else if (wr_cmd && i_pwdata[fsp_pkg::FSP_CMD_WREN_BIT]) begin
            wel_reg <= 1'b1;
         end
      end
   end

   // Busy flag, auto-increment mode and operation launch.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         busy_reg <= 1'b0;
         aai_reg <= 1'b0;
         aai_addr_reg <= '0;
         reject_reg <= 1'b0;
         o_op_start <= 1'b0;
         o_op_kind <= 3'h0;
         o_op_addr <= '0;
      end else if (i_clk_en) begin
         o_op_start <= 1'b0;
         if (pin_reset) begin
            busy_reg <= 1'b0;
            aai_reg <= 1'b0;
         end else if (busy_reg) begin
            if (i_op_done) begin
               busy_reg <= 1'b0;
               if (aai_reg) begin
                  aai_addr_reg <= aai_next[ADDR_W-1:0];
                  aai_reg <= !aai_end;
               end
            end
         end else if (wr_cmd && i_pwdata[fsp_pkg::FSP_CMD_WRITE_DISABLE_CMD_BIT]) begin
            aai_reg <= 1'b0;
         end else if (wr_op) begin
            reject_reg <= !op_ok;
            if (op_ok) begin
               busy_reg <= 1'b1;
               o_op_start <= 1'b1;
               o_op_kind <= op_kind;
               o_op_addr <= op_addr;
               if (op_kind == fsp_pkg::FSP_OP_AAI_START) begin
                  aai_reg <= 1'b1;
                  aai_addr_reg <= op_addr;
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_status <= 8'h1c;
      end else if (i_clk_en) begin
         o_status <= status_byte;
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);

   a_pause_mode_sticky: assert property ($rose(pin_mode_reg) |=> pin_mode_reg [*8])
      else $error("pause pin mode reverted");
   a_hold_needs_select: assert property ($rose(hold_reg) |-> $past(!cs_s))
      else $error("pause entered without select");
   a_hold_entry_low: assert property ($rose(hold_reg) |-> $past(!sck_s && !pin_s))
      else $error("pause entered with clock high");
   a_hold_exit_low: assert property ($fell(hold_reg) && !o_seq_abort
      |-> $past(!sck_s && pin_s))
      else $error("pause left with clock high");
   a_held_output_float: assert property (hold_reg && i_clk_en |=> !o_so_oe && !o_bit_clk)
      else $error("output or bit clock active while paused");
   a_select_abort: assert property (hold_reg && cs_s && i_clk_en |=> !hold_reg && o_seq_abort)
      else $error("select rise did not abort pause");
   a_lock_freeze: assert property (wr_status && !wp_s && lock_reg && i_clk_en
      |=> $stable(lvl_reg) && $stable(lock_reg))
      else $error("locked status changed");
   a_busy_refuse: assert property (busy_reg && acc && i_pwrite && !pready_reg |=> o_pslverr)
      else $error("write accepted while busy");
   a_latch_gates_op: assert property (o_op_start |-> $past(wel_reg))
      else $error("operation started without write enable");
   a_status_clears_latch: assert property (wr_status && i_clk_en |=> !wel_reg)
      else $error("status write left latch set");
   a_range_blocked: assert property (o_op_start && o_op_kind != fsp_pkg::FSP_OP_CHIP
      |-> !prot_hit($past(lvl_reg[2:0]), o_op_addr))
      else $error("operation started in protected range");
   a_chip_clean: assert property (o_op_start && o_op_kind == fsp_pkg::FSP_OP_CHIP
      |-> $past(lvl_reg) == 4'h0)
      else $error("chip erase with protection set");

   c_pause_resume: cover property ($rose(hold_reg) ##[1:200] $fell(hold_reg) && !o_seq_abort);
   c_pause_abort: cover property (hold_reg ##1 o_seq_abort);
   c_op_done: cover property (o_op_start ##[1:50] (busy_reg && i_op_done));
   c_locked_write: cover property (wr_status && !status_ok);
endmodule

// *** tb/fsp_spi_host.sv ***
// Behavioural serial host giving select and a serial clock of its own phase.
module fsp_spi_host (
   input wire logic i_frame,
   input wire logic i_stall,
   output logic o_sck,
   output logic o_cs_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Select stays low for the whole frame, through any pause.
   assign o_cs_n = ~i_frame;
   // The clock runs only inside frames; a stall parks it at its present level.
   initial begin
      o_sck = 1'b0;
      #7;
      forever begin
         #80;
         if (!i_frame) begin
            o_sck = 1'b0;
         end else if (!i_stall) begin
            o_sck = ~o_sck;
         end
      end
   end
endmodule

// *** tb/flash_status_protect_hold_tb.sv ***
// Self-checking bench for the status, protection and pause block.
module flash_status_protect_hold_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] off_st = fsp_pkg::FSP_OFF_STATUS;
   localparam logic [7:0] off_cmd = fsp_pkg::FSP_OFF_CMD;
   localparam logic [7:0] off_op = fsp_pkg::FSP_OFF_OP;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, pin_n, wp_n, so_drive, op_done, en;
   logic [2:0] op_kind;
   logic so_oe, bit_clk, freeze, abort, dev_reset, op_start, sck, cs_n, frame, stall, err;
   logic [7:0] paddr, status, exp_st;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] op_addr, a;
   int failures = 0;
   int n_compared = 0;
   fsp_status_protect u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sck(sck), .i_cs_n(cs_n),
      .i_pause_rst_n(pin_n), .i_wp_n(wp_n), .i_so_drive(so_drive), .i_op_done(op_done),
      .o_so_oe(so_oe), .o_bit_clk(bit_clk), .o_seq_freeze(freeze), .o_seq_abort(abort),
      .o_dev_reset(dev_reset), .o_op_start(op_start), .o_op_kind(op_kind), .o_op_addr(op_addr),
      .o_status(status));
   fsp_spi_host u_host (.i_frame(frame), .i_stall(stall), .o_sck(sck), .o_cs_n(cs_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return freeze;
         1: return sck;
         2: return abort;
         default: return bit_clk;
      endcase
   endfunction
   task automatic wait_for(input int w, input logic v);
      int n;
      n = 0;
      while (pick(w) !== v && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (pick(w) !== v) begin
         failures++;
         $display("timeout at %0t waiting on signal %0d", $time, w);
         end_sim();
      end
   endtask
   function automatic logic prot(input logic [3:0] l, input logic [19:0] ad);
      case (l[2:0])
         3'd0: return 1'b0;
         3'd1: return ad >= fsp_pkg::FSP_BASE_L1;
         3'd2: return ad >= fsp_pkg::FSP_BASE_L2;
         3'd3: return ad >= fsp_pkg::FSP_BASE_L3;
         3'd4: return ad >= fsp_pkg::FSP_BASE_L4;
         default: return 1'b1;
      endcase
   endfunction
   // Sets the latch, starts an operation, and finishes it when accepted.
   task automatic do_op(input logic [2:0] k, input logic [19:0] ad, input logic acc);
      apb(1'b1, off_cmd, 32'h1);
      apb(1'b1, off_op, {9'h0, k, ad});
      @(posedge clk);
      check(op_start, acc);
      apb(1'b0, off_st, 0);
      check(rd[1:0], acc ? 2'b11 : 2'b10);
      if (acc) begin
         check(op_addr, ad);
         check(op_kind, k);
         apb(1'b0, off_cmd, 0);
         check(err, 1'b1);
         @(posedge clk);
         op_done <= 1'b1;
         @(posedge clk);
         op_done <= 1'b0;
         apb(1'b0, off_st, 0);
         check(rd[1:0], 2'b00);
      end else begin
         apb(1'b1, off_cmd, 32'h2);
      end
   endtask
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, op_done, frame, stall} = '0;
      {paddr, pwdata} = '0;
      {pin_n, wp_n, so_drive, en} = 4'b1111;
      void'($urandom(32'h1b42));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, off_st, 0);
      check(rd, 32'h1c);
      apb(1'b0, 8'h0c, 0);
      check(err, 1'b1);
      en <= 1'b0;
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      check({dev_reset, status}, 9'h01c);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      en <= 1'b1;
      repeat (4) @(posedge clk);
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) begin
         wp_n <= 1'b1;
         repeat (4) @(posedge clk);
         exp_st = {i[0], 7'h28};
         apb(1'b1, off_st, {24'h0, i[0], 7'h6b});
         apb(1'b0, off_st, 0);
         check(rd, exp_st);
         wp_n <= i[1];
         repeat (4) @(posedge clk);
         apb(1'b1, off_cmd, 32'h1);
         apb(1'b1, off_st, {24'h0, 8'h14 | (8'($urandom) & 8'h43)});
         if (i[1] || !i[0]) exp_st = 8'h14;
         apb(1'b0, off_st, 0);
         check(rd, exp_st);
      end
      wp_n <= 1'b1;
      repeat (4) @(posedge clk);
      $display("test status_write done");
      for (int l = 0; l < 9; l++) begin
         apb(1'b1, off_st, {26'h0, l[3:0], 2'b00});
         for (int j = 0; j < 3; j++) begin
            a = (j == 0) ? 20'($urandom) : (j == 1) ? 20'hfffff : 20'h7ffff;
            do_op(3'(fsp_pkg::FSP_OP_BYTE), a, !prot(l[3:0], a));
         end
         do_op(3'(fsp_pkg::FSP_OP_CHIP), 20'h0, l == 0);
      end
      apb(1'b1, off_st, 0);
      apb(1'b1, off_op, 32'h0);
      @(posedge clk);
      check(op_start, 1'b0);
      apb(1'b1, off_op, 32'h0070_0000);
      check(err, 1'b1);
      apb(1'b1, off_cmd, 32'h1);
      apb(1'b1, off_op, {9'h0, 3'(fsp_pkg::FSP_OP_AAI_START), 20'h0});
      @(posedge clk);
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      apb(1'b0, off_st, 0);
      check(rd, 32'h42);
      apb(1'b1, off_cmd, 32'h2);
      apb(1'b0, off_st, 0);
      check(rd, 32'h00);
      $display("test operations done");
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      check({dev_reset, status}, 9'h11c);
      pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b1, off_cmd, 32'h4);
      apb(1'b0, off_cmd, 0);
      check(rd[0], 1'b1);
      frame <= 1'b1;
      wait_for(3, 1'b1);
      wait_for(1, 1'b1);
      stall <= 1'b1;
      pin_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(freeze, 1'b0);
      stall <= 1'b0;
      wait_for(0, 1'b1);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         check({freeze, so_oe, bit_clk}, 3'b100);
      end
      wait_for(1, 1'b1);
      stall <= 1'b1;
      pin_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(freeze, 1'b1);
      stall <= 1'b0;
      wait_for(0, 1'b0);
      repeat (3) @(posedge clk);
      check(so_oe, 1'b1);
      pin_n <= 1'b0;
      wait_for(0, 1'b1);
      frame <= 1'b0;
      wait_for(2, 1'b1);
      repeat (6) @(posedge clk);
      check({freeze, dev_reset}, 2'b00);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      frame <= 1'b1;
      wait_for(3, 1'b1);
      frame <= 1'b0;
      $display("test pause done");
      end_sim();
   end
endmodule
